/* design/adc_ctrl_pkg.sv */
// How it works
// RL1 - Sample fixed delay after conversion clock falls
// RL2 - Host keeps conversion clock 300 kHz-2.5 MHz
// RL3 - Host never stops clock mid conversion
// RL4 - Calibrate high two clocks enters calibration
// RL5 - Reset high two clocks resets converter
// RL6 - Host resets before first calibration
// RL7 - Host calibrates after every power-up
// RL8 - Read enable low drives result bus
// RL9 - Read enable high releases result bus
// RL10 - Power-down low holds converter inactive
// RL11 - Power-down high allows normal converting
// RL12 - Done flag low marks fresh result
// RL13 - Result is 14-bit two's complement word
// RL14 - Done flag high in reset, calibration, power-down
// RL15 - Calibration ends alone; one result per period
package adc_ctrl_pkg;

    localparam int RESULT_W     = 14;
    localparam int REG_AW       = 4;
    localparam int REG_DW       = 8;
    localparam int CLK_PERIOD_NS = 8;

    // Conversion clock fall to sampling instant
    localparam int SAMPLE_DELAY_NS  = 16;
    localparam logic [3:0] SAMPLE_DELAY_CYC =
        4'((SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Level inputs must be seen over this many conversion clock falls
    localparam logic [1:0] HOLD_FALLS = 2'h2;

    // Register offsets
    localparam logic [REG_AW-1:0] OFF_STATUS = 4'h0;
    localparam logic [REG_AW-1:0] OFF_MASK   = 4'h4;
    localparam logic [REG_AW-1:0] OFF_STATE  = 4'h8;

    // Status bit positions
    localparam int EV_RESULT  = 0;
    localparam int EV_CALDONE = 1;
    localparam int EV_OVERRUN = 2;
    localparam int EV_RSTDONE = 3;
    localparam int EV_W       = 4;

    localparam logic [EV_W-1:0] STATUS_RST = 4'h0;
    localparam logic [EV_W-1:0] MASK_RST   = 4'h0;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RUN   = 2'b01,
        ST_CAL   = 2'b10,
        ST_PDOWN = 2'b11
    } conv_state_type;

endpackage

/* design/adc_control_and_output_port.sv */
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module adc_control_and_output_port
    import adc_ctrl_pkg::*;
#(
    parameter logic [15:0] CAL_CONV_CYCLES = 16'h0040
)(
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst_b,
    // Converter pins from the host
    input  wire logic                i_conv_clk,
    input  wire logic                i_cal,
    input  wire logic                i_reset_req,
    input  wire logic                i_power_down_n,
    input  wire logic                i_read_n,
    // Quantizer code, offset binary, same clock domain
    input  wire logic [RESULT_W-1:0] i_sample,
    // Converter pins to the host
    output logic                     o_conv_done_n,
    output logic [RESULT_W-1:0]      o_result_bus,
    output logic                     o_result_oe,
    // Register port
    input  wire logic [REG_AW-1:0]   i_addr,
    input  wire logic [REG_DW-1:0]   i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic [REG_DW-1:0]        o_rdata,
    output logic                     o_irq
);

    localparam int SD = int'(SAMPLE_DELAY_CYC);

    function automatic logic reg_hit(input logic [REG_AW-1:0] a,
                                     input logic [REG_AW-1:0] off);
        reg_hit = (a == off);
    endfunction

    // Pin synchronisers: conv clock, cal, reset, power-down, read
    logic [4:0]            sync1;
    logic [4:0]            sync2;
    logic                  conv_d;
    logic                  conv_fall;
    logic                  cal_s;
    logic                  rst_s;
    logic                  pd_s;
    logic                  read_n_s;

    conv_state_type        state;
    conv_state_type        next_state;
    logic [1:0]            rst_cnt;
    logic [1:0]            cal_cnt;
    logic                  rst_active;
    logic                  cal_hit;
    logic [15:0]           cal_left;
    logic [3:0]            dly_cnt;
    logic                  sample_stb;
    logic [RESULT_W-1:0]   result;
    logic                  read_seen;
    logic [EV_W-1:0]       status;
    logic [EV_W-1:0]       mask;
    logic [EV_W-1:0]       events;
    logic                  status_wr;
    logic                  mask_wr;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            sync1 <= 5'h13;
            sync2 <= 5'h13;
        end
        else
        begin
            sync1 <= {i_conv_clk, i_cal, i_reset_req, i_power_down_n,
                      i_read_n};
            sync2 <= sync1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            conv_d <= 1'b1;
        else
            conv_d <= sync2[4];
    end

    assign conv_fall = conv_d & ~sync2[4];
    assign cal_s     = sync2[3];
    assign rst_s     = sync2[2];
    assign pd_s      = sync2[1];
    assign read_n_s  = sync2[0];

    // Count conversion clock falls while a level input stays high
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            rst_cnt <= 2'h0;
        else if (!rst_s)
            rst_cnt <= 2'h0;
        else if (conv_fall && rst_cnt != HOLD_FALLS)
            rst_cnt <= rst_cnt + 2'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            cal_cnt <= 2'h0;
        else if (!cal_s)
            cal_cnt <= 2'h0;
        else if (conv_fall && cal_cnt != HOLD_FALLS)
            cal_cnt <= cal_cnt + 2'h1;
    end

    // Reset acts for as long as the qualified level stays high
    assign rst_active = rst_s && rst_cnt == HOLD_FALLS;  // [RL5]
    // Calibration is taken once per high level, so holding it
    // high does not restart the sequence
    assign cal_hit = conv_fall && cal_s
                   && cal_cnt == HOLD_FALLS - 2'h1;      // [RL4]

    always_comb
    begin
        next_state = state;
        if (rst_active)
            next_state = ST_RESET;                       // [RL5]
        else if (!pd_s)
            next_state = ST_PDOWN;                       // [RL10]
        else
        begin
            case (state)
                ST_RESET: next_state = ST_RUN;
                ST_PDOWN: next_state = ST_RUN;           // [RL11]
                ST_RUN:
                    if (cal_hit)
                        next_state = ST_CAL;             // [RL4]
                ST_CAL:
                    if (conv_fall && cal_left == 16'h0001)
                        next_state = ST_RUN;             // [RL15]
                default: next_state = ST_RESET;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            cal_left <= 16'h0000;
        else if (state != ST_CAL)
            cal_left <= CAL_CONV_CYCLES;
        else if (conv_fall && cal_left != 16'h0000)
            cal_left <= cal_left - 16'h0001;
    end

    // Sampling instant trails each fall by a fixed delay
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            dly_cnt <= 4'h0;
        else if (next_state != ST_RUN)
            dly_cnt <= 4'h0;
        else if (conv_fall && state == ST_RUN)
            dly_cnt <= SAMPLE_DELAY_CYC;                 // [RL1]
        else if (dly_cnt != 4'h0)
            dly_cnt <= dly_cnt - 4'h1;
    end

    assign sample_stb = (dly_cnt == 4'h1);               // [RL1]

    // Offset binary to two's complement by flipping the sign bit
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            result <= '0;
        else if (sample_stb)
            result <= {~i_sample[RESULT_W-1],
                       i_sample[RESULT_W-2:0]};          // [RL13]
    end

    // Done flag falls with each fresh result, rises at next fall
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_conv_done_n <= 1'b1;
        else if (state != ST_RUN)
            o_conv_done_n <= 1'b1;                       // [RL14]
        else if (sample_stb)
            o_conv_done_n <= 1'b0;                       // [RL12] [RL15]
        else if (conv_fall)
            o_conv_done_n <= 1'b1;
    end

    // Bus released whenever read is high; low when released
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_result_oe  <= 1'b0;
            o_result_bus <= '0;
        end
        else
        begin
            o_result_oe  <= ~read_n_s;                   // [RL8] [RL9]
            o_result_bus <= read_n_s ? '0 : result;      // [RL8] [RL9]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            read_seen <= 1'b1;
        else if (sample_stb)
            read_seen <= 1'b0;
        else if (!read_n_s)
            read_seen <= 1'b1;
    end

    // Interrupt events
    always_comb
    begin
        events              = '0;
        events[EV_RESULT]   = sample_stb;
        events[EV_CALDONE]  = state == ST_CAL && next_state == ST_RUN;
        events[EV_OVERRUN]  = sample_stb && !read_seen;
        events[EV_RSTDONE]  = state == ST_RESET && next_state != ST_RESET;
    end

    assign status_wr = i_wr && reg_hit(i_addr, OFF_STATUS);
    assign mask_wr   = i_wr && reg_hit(i_addr, OFF_MASK);

    // A new event wins over a write-one clear in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            status <= STATUS_RST;
        else if (status_wr)
            status <= (status & ~i_wdata[EV_W-1:0]) | events;
        else
            status <= status | events;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            mask <= MASK_RST;
        else if (mask_wr)
            mask <= i_wdata[EV_W-1:0];
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_irq <= 1'b0;
        else
            o_irq <= |(status & mask);
    end

    // Read data valid in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_rdata <= '0;
        else if (!i_rd)
            o_rdata <= '0;
        else if (reg_hit(i_addr, OFF_STATUS))
            o_rdata <= {{(REG_DW-EV_W){1'b0}}, status};
        else if (reg_hit(i_addr, OFF_MASK))
            o_rdata <= {{(REG_DW-EV_W){1'b0}}, mask};
        else if (reg_hit(i_addr, OFF_STATE))
            o_rdata <= {6'h00, state};
        else
            o_rdata <= '0;
    end

    a_sample_delay: assert property (   // [RL1]
        @(posedge i_clk) disable iff (!i_rst_b)
        sample_stb |-> $past(conv_fall, SD) && state == ST_RUN)
        else $error("sample not at fixed delay after clock fall");

    a_cal_entry: assert property (   // [RL4]
        @(posedge i_clk) disable iff (!i_rst_b)
        cal_hit && !rst_active && pd_s && state == ST_RUN
        |=> state == ST_CAL)
        else $error("calibration not entered");

    a_reset_hold: assert property (   // [RL5]
        @(posedge i_clk) disable iff (!i_rst_b)
        rst_active |=> state == ST_RESET && o_conv_done_n)
        else $error("converter not held in reset");

    a_bus_drive: assert property (   // [RL8]
        @(posedge i_clk) disable iff (!i_rst_b)
        !read_n_s |=> o_result_oe && o_result_bus == $past(result))
        else $error("result bus not driven during read");

    a_bus_release: assert property (   // [RL9]
        @(posedge i_clk) disable iff (!i_rst_b)
        read_n_s |=> !o_result_oe && o_result_bus == '0)
        else $error("result bus not released");

    a_pd_enter: assert property (   // [RL10]
        @(posedge i_clk) disable iff (!i_rst_b)
        !pd_s && !rst_active |=> state == ST_PDOWN ##1 o_conv_done_n)
        else $error("power-down not entered");

    a_pd_resume: assert property (   // [RL11]
        @(posedge i_clk) disable iff (!i_rst_b)
        state == ST_PDOWN && pd_s && !rst_active |=> state == ST_RUN)
        else $error("converter did not resume");

    a_done_flag: assert property (   // [RL12]
        @(posedge i_clk) disable iff (!i_rst_b)
        sample_stb && state == ST_RUN && next_state == ST_RUN
        |=> !o_conv_done_n && status[EV_RESULT])
        else $error("done flag missing after result");

    a_twos_comp: assert property (   // [RL13]
        @(posedge i_clk) disable iff (!i_rst_b)
        sample_stb |=> result == {~$past(i_sample[RESULT_W-1]),
                                  $past(i_sample[RESULT_W-2:0])})
        else $error("result not two's complement of sample");

    a_done_idle: assert property (   // [RL14]
        @(posedge i_clk) disable iff (!i_rst_b)
        state != ST_RUN |=> o_conv_done_n)
        else $error("done flag low outside normal mode");

    a_cal_return: assert property (   // [RL15]
        @(posedge i_clk) disable iff (!i_rst_b)
        state == ST_CAL && conv_fall && cal_left == 16'h0001
        && pd_s && !rst_active |=> state == ST_RUN && status[EV_CALDONE])
        else $error("calibration did not end on its own");

endmodule // adc_control_and_output_port

/* bench/adc_host_model.sv */
`timescale 1ns/1ps
module adc_host_model (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // Commands from the bench
    input  wire logic i_go_reset,
    input  wire logic i_go_cal,
    // Pins to the converter
    output logic      o_conv_clk,
    output logic      o_reset_req,
    output logic      o_cal
);
    logic [5:0] div;
    logic [7:0] hold;
    logic       mode;

    // Fastest legal rate; never stopped, so no conversion is cut short
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            div        <= 6'h00;
            o_conv_clk <= 1'b1;
        end
        else
        begin
            div <= (div == 6'h18) ? 6'h00 : div + 6'h01;
            if (div == 6'h18)
                o_conv_clk <= ~o_conv_clk;
        end
    end

    // Levels held about three periods, above the two-clock minimum
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            hold <= 8'h00;
        else if (i_go_reset || i_go_cal)
            hold <= 8'ha0;
        else if (hold != 8'h00)
            hold <= hold - 8'h01;
        if (i_go_reset)
            mode <= 1'b0;
        else if (i_go_cal)
            mode <= 1'b1;
    end

    assign o_reset_req = (hold != 8'h00) && !mode;
    assign o_cal       = (hold != 8'h00) && mode;
endmodule // adc_host_model

/* bench/adc_control_and_output_port_tb_top.sv */
`timescale 1ns/1ps
module adc_control_and_output_port_tb_top;
    import adc_ctrl_pkg::*;
    logic i_clk, i_rst_b, go_reset, go_cal, conv_clk, reset_req, cal;
    logic i_power_down_n, i_read_n, i_wr, i_rd, o_conv_done_n;
    logic o_result_oe, o_irq;
    logic [RESULT_W-1:0] i_sample, o_result_bus, expv;
    logic [REG_AW-1:0]   i_addr;
    logic [REG_DW-1:0]   i_wdata, o_rdata, v;
    logic [31:0]         seed;
    int err_count, total_checks, n;

    adc_host_model host (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_go_reset(go_reset), .i_go_cal(go_cal), .o_conv_clk(conv_clk),
        .o_reset_req(reset_req), .o_cal(cal));

    adc_control_and_output_port #(.CAL_CONV_CYCLES(16'h0004)) dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_conv_clk(conv_clk),
        .i_cal(cal), .i_reset_req(reset_req),
        .i_power_down_n(i_power_down_n), .i_read_n(i_read_n),
        .i_sample(i_sample), .o_conv_done_n(o_conv_done_n),
        .o_result_bus(o_result_bus), .o_result_oe(o_result_oe),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq));

    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic report_and_stop();
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask

    // Waits for the done flag to go high and then low again
    task automatic wait_fall(output int k);
        bit hi;
        hi = 0;
        for (k = 1; k < 300; k++)
        begin
            cyc(1);
            if (o_conv_done_n === 1'b1)
                hi = 1;
            else if (hi && o_conv_done_n === 1'b0)
                return;
        end
        err_count++;
        report_and_stop();
    endtask

    initial
    begin
        seed = 32'h0000_f2f7;
        i_rst_b = 0; go_reset = 0; go_cal = 0; i_power_down_n = 1;
        i_read_n = 1; i_wr = 0; i_rd = 0; i_addr = 0; i_wdata = 0;
        i_sample = 0;
        cyc(10);
        i_rst_b <= 1'b1;
        cyc(2);
        chk(o_conv_done_n, 1);
        chk(o_result_oe, 0);
        // Drop the flag left by the bench reset so the pin reset sets it
        wr(OFF_STATUS, 8'h0f);
        @(posedge i_clk) go_reset <= 1'b1;
        @(posedge i_clk) go_reset <= 1'b0;
        cyc(120);
        rd(OFF_STATE, v);
        chk(v, 0);
        cyc(60);
        rd(OFF_STATE, v);
        chk(v, 1);
        rd(OFF_STATUS, v);
        chk(v & 8'h08, 8'h08);
        @(posedge i_clk) go_cal <= 1'b1;
        @(posedge i_clk) go_cal <= 1'b0;
        cyc(150);
        rd(OFF_STATE, v);
        chk(v, 2);
        chk(o_conv_done_n, 1);
        cyc(300);
        rd(OFF_STATE, v);
        chk(v, 1);
        rd(OFF_STATUS, v);
        chk(v & 8'h02, 8'h02);
        i_read_n <= 1'b0;
        seed = xs(seed);
        i_sample <= 14'h3fff; // Corner: largest positive after flip
        expv = 14'h1fff;
        wait_fall(n);
        for (int i = 0; i < 12; i++)
        begin
            wait_fall(n);
            if (i > 0)
                chk(n + 2, 50);
            cyc(2);
            chk(o_result_oe, 1);
            chk(o_result_bus, expv);
            seed = xs(seed);
            i_sample <= seed[13:0];
            expv = seed[13:0] ^ 14'h2000;
        end
        i_read_n <= 1'b1;
        cyc(5);
        chk(o_result_oe, 0);
        chk(o_result_bus, 0);
        wr(OFF_MASK, 8'h01);
        rd(OFF_MASK, v);
        chk(v, 8'h01);
        cyc(2);
        chk(o_irq, 1);
        wr(OFF_MASK, 8'h00);
        wr(OFF_STATUS, 8'h0f);
        cyc(2);
        chk(o_irq, 0);
        rd(4'hc, v);
        chk(v, 0);
        // Results keep coming with the bus released, so overrun must set
        cyc(120);
        rd(OFF_STATUS, v);
        chk(v & 8'h04, 8'h04);
        i_power_down_n <= 1'b0;
        cyc(120);
        rd(OFF_STATE, v);
        chk(v, 3);
        chk(o_conv_done_n, 1);
        i_power_down_n <= 1'b1;
        wait_fall(n);
        wait_fall(n);
        chk(n, 50);
        report_and_stop();
    end
endmodule // adc_control_and_output_port_tb_top
